// File: hdl/mfe_front_end.sv
`timescale 1ns/1ps
// front end configuration bank and transmit port assembly
module mfe_front_end
	import mfe_pkg::*;
#(
	parameter int TUNE_CYC   = TUNE_CYCLES,
	parameter int PERIOD_CYC = PERIOD_CYCLES
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	mfe_link_if.dev           link,
	input  wire logic         rx_nonmux_mode,   // six-bit receive data mode
	output logic [3:0]        dac_clk_mult,     // DAC clock factor
	output logic [2:0]        rx_clk_mult,      // receive generator multiplier
	output logic [2:0]        rx_clk_div,       // receive generator divider
	output logic              rx_clk_half,      // receive clock output halved
	output logic              adc_clk_from_rx,  // ADC fed from receive generator / 2
	output logic              rx_sync_half,     // receive sync at half clock rate
	output logic              tx_neg_edge,      // sample transmit on falling edge
	output logic              lpf_bypass,       // four-pole filter bypassed
	output logic              lpf_powerdown,    // four-pole filter powered down
	output logic              one_pole_en,      // extra single-pole filter in path
	output logic              lpf_wideband,     // wideband cutoff selected
	output logic              fast_bias,        // raised gain stage bias
	output logic              hpf_bypass,       // digital high-pass removed
	output logic [8:0]        cutoff_num,       // cutoff ratio numerator
	output logic [8:0]        cutoff_den,       // cutoff ratio denominator
	output logic              offset_busy,      // offset correction running
	output logic              tune_busy,        // filter calibration running
	output logic signed [7:0] rx_gain_db,       // applied gain
	output logic signed [7:0] coarse_gain_stage_db,
	output logic signed [7:0] fine_gain_stage_db,
	output logic [2:0]        interp_rate,      // 1, 2 or 4
	output interp_kind_t      interp_kind,
	output logic              interp_powerdown, // interpolator off, DAC silent
	output logic [11:0]       tx_sample,        // assembled transmit word
	output logic              tx_sample_valid   // one-cycle pulse
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  clk_src;   // clock source configuration
		logic [5:0]  filt;      // stored filter bits 4:0 and bit 7
		logic [7:0]  tune_tgt;  // tuning target
		logic        gain_src;  // gain set by register
		logic [4:0]  gain;      // applied gain code
		logic [7:0]  tx_set;    // transmit settings
		logic [7:0]  offs_cnt;  // offset correction countdown
		logic        tuning;    // calibration running
		logic [28:0] tune_cnt;  // calibration time
		logic [28:0] per_cnt;   // time since last calibration
		logic        ack;
		logic [7:0]  rdata;
		logic [5:0]  half;      // first half of a word
		logic        have_half;
		logic [11:0] sample;
		logic        sample_v;
	} state_t;

	state_t s_q;   // registered state
	state_t s_d;   // next state
	logic   wr_go; // register write this cycle
	logic   rd_go; // register read this cycle

	// gain code to stage split, wideband limits the top codes
	function automatic logic [15:0] gain_split(input logic [4:0] c, input logic wide);
		logic signed [7:0] cg;
		logic signed [7:0] fg;
		cg = 8'sh00;
		fg = 8'sh00;
		if (c <= 5'h05) begin
			cg = -8'sd6;
			fg = 8'(2 * c);
		end else if (c <= 5'h11) begin
			cg = 8'(6 * ((c - 5'h06) / 3));
			fg = 8'(6 + 2 * ((c - 5'h06) % 3));
		end else if (wide) begin
			cg = 8'sd18;
			fg = 8'sd12;
		end else begin
			cg = 8'sd24;
			fg = 8'(6 + 2 * (c - GAIN_WIDE_CODE));
		end
		return {cg, fg};
	endfunction

	assign wr_go = link.reg_req & link.reg_wr & ~s_q.ack;
	assign rd_go = link.reg_req & ~link.reg_wr & ~s_q.ack;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.sample_v = 1'b0;
		// offset correction countdown
		if (s_q.offs_cnt != 8'h00) begin
			s_d.offs_cnt = s_q.offs_cnt - 8'h01;
		end
		// calibration timing, periodic restart unless disabled
		if (s_q.tuning) begin
			s_d.tune_cnt = s_q.tune_cnt + 29'h1;
			if (s_q.tune_cnt >= 29'(TUNE_CYC - 1)) begin
				s_d.tuning = 1'b0;
				s_d.per_cnt = 29'h0;
			end
		end else if (!s_q.filt[5]) begin
			s_d.per_cnt = s_q.per_cnt + 29'h1;
			if (s_q.per_cnt >= 29'(PERIOD_CYC - 1)) begin
				s_d.tuning = 1'b1;
				s_d.tune_cnt = 29'h0;
			end
		end
		// pin gain load while pins own the gain
		if (!s_q.gain_src && link.gain_strobe) begin
			s_d.gain = (link.tx_data[5:1] > GAIN_MAX_CODE) ? GAIN_MAX_CODE : link.tx_data[5:1];
		end
		// register access, one ack per request
		if (wr_go || rd_go) begin
			s_d.ack = 1'b1;
		end
		if (wr_go) begin
			unique case (link.reg_addr)
				REG_CLK_SRC: s_d.clk_src = link.reg_wdata;
				REG_FILT_SEL: begin
					// tuning flag not writable, offset bit only triggers
					s_d.filt = {link.reg_wdata[FLT_NO_AUTO], link.reg_wdata[4:0]};
					if (link.reg_wdata[FLT_OFFSET]) begin
						s_d.offs_cnt = OFFSET_CAL_CYCLES;
					end
					if (!link.reg_wdata[FLT_NO_AUTO]) begin
						s_d.tuning = 1'b1;
						s_d.tune_cnt = 29'h0;
					end
				end
				REG_TUNE_TGT: s_d.tune_tgt = link.reg_wdata;
				REG_GAIN: begin
					s_d.gain_src = link.reg_wdata[GAIN_SRC_REG];
					if (link.reg_wdata[GAIN_SRC_REG]) begin
						// codes above the table saturate at the top code
						s_d.gain = (link.reg_wdata[4:0] > GAIN_MAX_CODE) ?
							GAIN_MAX_CODE : link.reg_wdata[4:0];
					end
				end
				REG_TX_SET: s_d.tx_set = link.reg_wdata;
				default: ; // unmapped writes dropped
			endcase
		end
		if (rd_go) begin
			unique case (link.reg_addr)
				REG_CLK_SRC:  s_d.rdata = s_q.clk_src;
				REG_FILT_SEL: s_d.rdata = {s_q.filt[5], s_q.tuning, s_q.offs_cnt != 8'h00,
					s_q.filt[4:0]};
				REG_TUNE_TGT: s_d.rdata = s_q.tune_tgt;
				REG_GAIN:     s_d.rdata = {2'b00, s_q.gain_src, s_q.gain};
				REG_TX_SET:   s_d.rdata = s_q.tx_set;
				default:      s_d.rdata = 8'h00; // unmapped reads zero
			endcase
		end
		// transmit word assembly, stopped while interpolator is quiet
		if (link.tx_valid && !interp_powerdown) begin
			if (s_q.tx_set[TX_DEMUX_BYP]) begin
				s_d.sample = {link.tx_data, 6'h00};
				s_d.sample_v = 1'b1;
			end else if (link.tx_sync) begin
				s_d.half = link.tx_data;
				s_d.have_half = 1'b1;
			end else if (s_q.have_half) begin
				s_d.sample = s_q.tx_set[TX_LS_FIRST] ? {link.tx_data, s_q.half} :
					{s_q.half, link.tx_data};
				s_d.sample_v = 1'b1;
				s_d.have_half = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers; calibration starts out of reset
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.clk_src <= RST_CLK_SRC;
			s_q.filt <= {RST_FILT_SEL[FLT_NO_AUTO], RST_FILT_SEL[4:0]};
			s_q.tune_tgt <= RST_TUNE_TGT;
			s_q.gain <= RST_GAIN;
			s_q.tx_set <= RST_TX_SET;
			s_q.tuning <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// decoded outputs
	// ----------------------------------------------------------------
	logic [15:0] split; // coarse and fine stage gains

	assign split = gain_split(s_q.gain, s_q.filt[FLT_WIDE]);
	assign coarse_gain_stage_db = split[15:8];
	assign fine_gain_stage_db = split[7:0];
	assign rx_gain_db = coarse_gain_stage_db + fine_gain_stage_db;
	assign dac_clk_mult = 4'h1 << s_q.clk_src[1:0];
	// code 11 is left to the host to avoid
	assign rx_clk_mult = (s_q.clk_src[5:4] == 2'b00) ? 3'd3 :
		(s_q.clk_src[5:4] == 2'b01) ? 3'd4 : 3'd6;
	assign rx_clk_div = (s_q.clk_src[3:2] == 2'b00) ? 3'd2 :
		(s_q.clk_src[3:2] == 2'b01) ? 3'd4 : 3'd1;
	assign rx_clk_half = rx_nonmux_mode;
	assign adc_clk_from_rx = s_q.clk_src[CLK_ADC_SRC];
	assign rx_sync_half = s_q.clk_src[CLK_ADC_SRC];
	assign tx_neg_edge = s_q.clk_src[CLK_TX_NEG];
	assign lpf_bypass = s_q.filt[FLT_BYPASS];
	assign lpf_powerdown = s_q.filt[FLT_BYPASS];
	assign one_pole_en = s_q.filt[FLT_ONE_POLE];
	assign lpf_wideband = s_q.filt[FLT_WIDE];
	assign fast_bias = s_q.filt[FLT_FAST];
	assign hpf_bypass = s_q.filt[FLT_HPF_BYP];
	assign cutoff_num = s_q.filt[FLT_WIDE] ? CUT_NUM_HIGH : CUT_NUM_LOW;
	assign cutoff_den = CUT_NUM_LOW + {1'b0, s_q.tune_tgt};
	assign offset_busy = s_q.offs_cnt != 8'h00;
	assign tune_busy = s_q.tuning;
	assign interp_powerdown = s_q.tx_set[TX_QUIET_EN] & ~link.quiet_n;
	assign tx_sample = s_q.sample;
	assign tx_sample_valid = s_q.sample_v;
	assign link.reg_ack = s_q.ack;
	assign link.reg_rdata = s_q.rdata;

	// interpolation mode from upper transmit bits
	always_comb begin
		interp_rate = 3'd4;
		interp_kind = INTERP_RSVD;
		unique case (s_q.tx_set[7:4])
			4'h0: interp_kind = INTERP_LPF;
			4'h1: begin
				interp_kind = INTERP_LPF;
				interp_rate = 3'd2;
			end
			4'h2: begin
				interp_kind = INTERP_BYPASS;
				interp_rate = 3'd1;
			end
			4'h4: interp_kind = INTERP_BPF_ADJ;
			4'h5: begin
				interp_kind = INTERP_BPF_ADJ;
				interp_rate = 3'd2;
			end
			4'h8: interp_kind = INTERP_BPF_LOW;
			4'hc: interp_kind = INTERP_BPF_UP;
			default: interp_kind = INTERP_RSVD; // undefined codes
		endcase
	end
endmodule

// File: hdl/mfe_pkg.sv
// Function
// - transmit multiplier code gives DAC clock factor
// - decode receive multiplier and divider codes
// - receive clock halves in six-bit mode
// - source bit high clocks ADC from receive generator
// - source bit low uses reference clock directly
// - negative edge bit selects falling sampling edge
// - cutoff ratio from tuning target, low/high
// - bypass bit skips and powers down filter
// - single-pole bit adds extra input filter
// - wideband bit widens cutoff, caps gain 30
// - fast sampling bit raises gain stage bias
// - host bypasses high-pass above fifty megasamples
// - offset bit starts correction, reads zero after
// - tuning busy flag read-only during calibration
// - calibrate at reset, periodically, bit7 controls
// - gain resets to code zero, 2 dB steps
// - gain read shows gain actually applied
// - gain source bit picks register or pins
// - gain code split into coarse and fine
// - demux bypass: each transfer a sample
// - nibble order bit sends low half first
// - quiet pin low powers down interpolator
// - upper transmit bits pick interpolation mode
package mfe_pkg;
	// ----------------------------------------------------------------
	// register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CLK_SRC   = 4'h3;
	localparam logic [3:0] REG_FILT_SEL  = 4'h4;
	localparam logic [3:0] REG_TUNE_TGT  = 4'h5;
	localparam logic [3:0] REG_GAIN      = 4'h6;
	localparam logic [3:0] REG_TX_SET    = 4'h7;
	localparam logic [7:0] RST_CLK_SRC   = 8'h02;
	localparam logic [7:0] RST_FILT_SEL  = 8'h01;
	localparam logic [7:0] RST_TUNE_TGT  = 8'h80;
	localparam logic [4:0] RST_GAIN      = 5'h00;
	localparam logic [7:0] RST_TX_SET    = 8'h00;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CLK_TX_NEG   = 7;
	localparam int CLK_ADC_SRC  = 6;
	localparam int FLT_BYPASS   = 0;
	localparam int FLT_ONE_POLE = 1;
	localparam int FLT_WIDE     = 2;
	localparam int FLT_FAST     = 3;
	localparam int FLT_HPF_BYP  = 4;
	localparam int FLT_OFFSET   = 5;
	localparam int FLT_TUNING   = 6;
	localparam int FLT_NO_AUTO  = 7;
	localparam int GAIN_SRC_REG = 5;
	localparam int TX_DEMUX_BYP = 0;
	localparam int TX_LS_FIRST  = 2;
	localparam int TX_QUIET_EN  = 3;
	localparam logic [4:0] GAIN_MAX_CODE  = 5'h15;
	localparam logic [4:0] GAIN_WIDE_CODE = 5'h12;
	localparam logic [8:0] CUT_NUM_LOW    = 9'd64;
	localparam logic [8:0] CUT_NUM_HIGH   = 9'd158;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ        = 200_000_000;
	localparam int TUNE_TIME_MS   = 500;
	localparam int TUNE_PERIOD_S  = 2;
	localparam int TUNE_CYCLES    = TUNE_TIME_MS * (MCLK_HZ / 1000);
	localparam int PERIOD_CYCLES  = TUNE_PERIOD_S * MCLK_HZ;
	localparam logic [7:0] OFFSET_CAL_CYCLES = 8'h40;
	// ----------------------------------------------------------------
	// host command port offsets (word index, byte address = 4x)
	// ----------------------------------------------------------------
	localparam logic [2:0] AV_CMD    = 3'h0;
	localparam logic [2:0] AV_STATUS = 3'h1;
	localparam logic [2:0] AV_TX     = 3'h2;
	localparam logic [2:0] AV_GAIN   = 3'h3;
	localparam logic [2:0] AV_QUIET  = 3'h4;
	localparam int CMD_RD_BIT   = 16;
	localparam int TX_SYNC_BIT  = 8;
	// ----------------------------------------------------------------
	// interpolation modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		INTERP_BYPASS, INTERP_LPF, INTERP_BPF_ADJ, INTERP_BPF_LOW, INTERP_BPF_UP, INTERP_RSVD
	} interp_kind_t;
endpackage

// File: hdl/mfe_link_if.sv
`timescale 1ns/1ps
// control port and transmit bus between processor and front end
interface mfe_link_if;
	logic       reg_req;     // register access request, held to ack
	logic       reg_wr;      // 1 write, 0 read
	logic [3:0] reg_addr;    // register offset
	logic [7:0] reg_wdata;   // write data
	logic       reg_ack;     // one-cycle answer
	logic [7:0] reg_rdata;   // read data, valid with ack
	logic [5:0] tx_data;     // transmit bus
	logic       tx_valid;    // one transfer per high cycle
	logic       tx_sync;     // first half of a word
	logic       gain_strobe; // load gain from tx_data[5:1]
	logic       quiet_n;     // quiet pin, active low
	modport dev  (input reg_req, reg_wr, reg_addr, reg_wdata, tx_data, tx_valid, tx_sync,
		gain_strobe, quiet_n, output reg_ack, reg_rdata);
	modport host (output reg_req, reg_wr, reg_addr, reg_wdata, tx_data, tx_valid, tx_sync,
		gain_strobe, quiet_n, input reg_ack, reg_rdata);
endinterface

// File: hdl/mfe_host_ctrl.sv
`timescale 1ns/1ps
// processor end: turns Avalon-MM orders into link traffic
module mfe_host_ctrl
	import mfe_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	mfe_link_if.host         link,
	input  wire logic [2:0]  address,     // word index
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        busy;     // link access in flight
		logic        req;
		logic        wr;
		logic [3:0]  addr;
		logic [7:0]  wdata;
		logic [7:0]  last_rd;  // last read answer
		logic        rd_ack;   // read data ready this cycle
		logic [31:0] rdata;
		logic [5:0]  tx_data;
		logic        tx_valid;
		logic        tx_sync;
		logic        gstrobe;
		logic        quiet_n;
	} state_t;

	state_t s_q; // registered state
	state_t s_d; // next state
	logic   wr_take; // write accepted this edge

	// a command write stalls while a link access is still open
	assign waitrequest = (read & ~s_q.rd_ack) | (write & s_q.busy & (address == AV_CMD));
	assign wr_take = write & ~waitrequest;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.tx_valid = 1'b0;
		s_d.gstrobe = 1'b0;
		s_d.rd_ack = read & ~s_q.rd_ack;
		// link answer closes the access
		if (s_q.req && link.reg_ack) begin
			s_d.req = 1'b0;
			s_d.busy = 1'b0;
			if (!s_q.wr) begin
				s_d.last_rd = link.reg_rdata;
			end
		end
		if (read && !s_q.rd_ack) begin
			unique case (address)
				AV_STATUS: s_d.rdata = {16'h0000, s_q.last_rd, 7'h00, s_q.busy};
				AV_QUIET:  s_d.rdata = {31'h0, s_q.quiet_n};
				default:   s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_take) begin
			unique case (address)
				AV_CMD: begin
					s_d.busy = 1'b1;
					s_d.req = 1'b1;
					s_d.wr = ~writedata[CMD_RD_BIT];
					s_d.addr = writedata[11:8];
					s_d.wdata = writedata[7:0];
				end
				AV_TX: begin
					s_d.tx_data = writedata[5:0];
					s_d.tx_sync = writedata[TX_SYNC_BIT];
					s_d.tx_valid = 1'b1;
				end
				AV_GAIN: begin
					s_d.tx_data = {writedata[4:0], 1'b0};
					s_d.gstrobe = 1'b1;
				end
				AV_QUIET: s_d.quiet_n = writedata[0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers; quiet pin idles high
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.quiet_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata = s_q.rdata;
	assign link.reg_req = s_q.req;
	assign link.reg_wr = s_q.wr;
	assign link.reg_addr = s_q.addr;
	assign link.reg_wdata = s_q.wdata;
	assign link.tx_data = s_q.tx_data;
	assign link.tx_valid = s_q.tx_valid;
	assign link.tx_sync = s_q.tx_sync;
	assign link.gain_strobe = s_q.gstrobe;
	assign link.quiet_n = s_q.quiet_n;
endmodule

// File: dv/mfe_link_properties.sv
`timescale 1ns/1ps
// protocol and readback checks on the processor to front end link
module mfe_link_properties
	import mfe_pkg::*;
(
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       reg_req,
	input wire logic       reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_ack,
	input wire logic [7:0] reg_rdata,
	input wire logic [5:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_sync,
	input wire logic       gain_strobe,
	input wire logic       quiet_n
);
	// ------
	// helper: cycles since an offset correction was started
	// ------
	logic [7:0] off_cnt_q; // saturates, so a stuck busy bit is caught
	logic [7:0] off_cnt_d;
	logic       off_start;
	assign off_start = reg_ack && reg_wr && reg_addr == REG_FILT_SEL && reg_wdata[FLT_OFFSET];
	// count up to saturation, clear on a start
	assign off_cnt_d = off_start ? 8'h00 : off_cnt_q + {7'h00, off_cnt_q != 8'hff};
	// register the helper
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			off_cnt_q <= 8'hff;
		end else begin
			off_cnt_q <= off_cnt_d;
		end
	end
	// ------
	// properties
	// ------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_taken;
		reg_req && !reg_ack;
	endsequence
	sequence s_answer;
		reg_ack ##1 (!reg_req && !reg_ack);
	endsequence
	a_ack_one_cycle: assert property ($rose(reg_req) |=> s_answer)
		else $error("late link answer");
	a_req_held: assert property (s_taken |=> reg_req && $stable(reg_addr)
		&& $stable(reg_wr) && $stable(reg_wdata))
		else $error("request changed early");
	a_ack_has_req: assert property (reg_ack |-> reg_req && $past(reg_req) && !$past(reg_ack))
		else $error("stray answer");
	a_gain_code_cap: assert property (reg_ack && !reg_wr && reg_addr == REG_GAIN
		|-> reg_rdata[4:0] <= GAIN_MAX_CODE && reg_rdata[7:6] == 2'b00)
		else $error("gain code range");
	a_offset_clears: assert property (reg_ack && !reg_wr && reg_addr == REG_FILT_SEL
		&& reg_rdata[FLT_OFFSET] |-> off_cnt_q <= 8'd68)
		else $error("offset bit stuck");
	a_strobe_shape: assert property (gain_strobe |-> tx_data[0] == 1'b0 ##1 !gain_strobe)
		else $error("gain strobe malformed");
	a_tx_pulse: assert property (tx_valid |=> !tx_valid)
		else $error("long transfer pulse");
	a_quiet_reset: assert property ($fell(sys_rst) |-> quiet_n && !reg_req && !tx_valid
		&& !gain_strobe)
		else $error("link busy after reset");
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
// host end and front end joined over the link
module tb
	import mfe_pkg::*;
;
	localparam int TUNE = 20; // shortened calibration
	localparam int PER  = 50; // shortened periodic gap
	localparam logic [2:0] MT [3] = '{3'd3, 3'd4, 3'd6};
	localparam logic [2:0] ND [3] = '{3'd2, 3'd4, 3'd1};
	localparam logic [3:0] IC [8] = '{4'h2, 4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hc, 4'h3};
	localparam logic [2:0] IR [8] = '{3'd1, 3'd4, 3'd2, 3'd4, 3'd2, 3'd4, 3'd4, 3'd4};
	localparam interp_kind_t IK [8] = '{INTERP_BYPASS, INTERP_LPF, INTERP_LPF, INTERP_BPF_ADJ,
		INTERP_BPF_ADJ, INTERP_BPF_LOW, INTERP_BPF_UP, INTERP_RSVD};
	logic        mclk      = 1'b0;
	logic        sys_rst   = 1'b1;
	logic [2:0]  address   = 3'h0;
	logic        read      = 1'b0;
	logic        write     = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic        nonmux    = 1'b0;
	logic [31:0] readdata, s;
	logic        waitrequest, rx_clk_half, adc_clk_from_rx, rx_sync_half, tx_neg_edge;
	logic        lpf_bypass, lpf_powerdown, one_pole_en, lpf_wideband, fast_bias, hpf_bypass;
	logic        offset_busy, tune_busy, interp_powerdown, tx_sample_valid;
	logic [3:0]  dac_clk_mult;
	logic [2:0]  rx_clk_mult, rx_clk_div, interp_rate;
	logic [8:0]  cutoff_num, cutoff_den;
	logic signed [7:0] rx_gain_db, coarse_gain_stage_db, fine_gain_stage_db;
	interp_kind_t interp_kind;
	logic [11:0] tx_sample, smp;
	logic [7:0]  q;
	int          mismatches = 0, total_checks = 0, cyc = 0, n_smp = 0, nt = 0;
	mfe_link_if link();
	// pins meet bench signals of the same name
	mfe_host_ctrl u_mfe_host_ctrl (.*);
	mfe_front_end #(.TUNE_CYC(TUNE), .PERIOD_CYC(PER)) u_mfe_front_end (.*,
		.rx_nonmux_mode(nonmux));
	mfe_link_properties u_mfe_link_properties (.mclk, .sys_rst, .reg_req(link.reg_req),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata), .tx_data(link.tx_data),
		.tx_valid(link.tx_valid), .tx_sync(link.tx_sync), .gain_strobe(link.gain_strobe),
		.quiet_n(link.quiet_n));
	// ------
	// clock, sample monitor, hang guard
	// ------
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (tx_sample_valid === 1'b1) begin
			smp <= tx_sample;
			n_smp <= n_smp + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	// ------
	// shared tasks
	// ------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// one Avalon access, held until waitrequest low
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0) @(posedge mclk);
		r = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	// link access by command word, polled until idle
	task automatic dev(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		av(1'b1, AV_CMD, {15'h0, !wr, 4'h0, a, d}, s);
		n = 0;
		do begin
			av(1'b0, AV_STATUS, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 50);
		q = s[15:8];
	endtask
	task automatic wait_tune;
		nt = 0;
		while (tune_busy === 1'b1 && nt < 200) begin
			@(posedge mclk);
			nt++;
		end
	endtask
	task automatic txs(input logic sy, input logic [5:0] d, input int cnt);
		int n;
		av(1'b1, AV_TX, {23'h0, sy, 2'h0, d}, s);
		n = 0;
		while (n_smp < cnt && n < 40) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset;
		wait_tune();
		chk("tune_len", nt >= TUNE - 3 && nt <= TUNE + 2, 1);
		dev(0, REG_FILT_SEL, 8'h0);
		chk("filt_rst", q, RST_FILT_SEL);
		dev(0, REG_CLK_SRC, 8'h0);
		chk("clk_rst", q, RST_CLK_SRC);
		dev(0, REG_TUNE_TGT, 8'h0);
		chk("tgt_rst", q, RST_TUNE_TGT);
		dev(0, REG_GAIN, 8'h0);
		chk("gain_rst", q, 8'h00);
		dev(0, REG_TX_SET, 8'h0);
		chk("tx_rst", q, RST_TX_SET);
		dev(0, 4'h9, 8'h0);
		chk("unmapped_link", q, 8'h00);
		av(1'b0, 3'h5, 32'h0, s);
		chk("unmapped_av", s, 32'h0);
		chk("dac_rst", dac_clk_mult, 4'd4);
		$display("t_reset done");
	endtask
	task automatic t_clk;
		logic [1:0] k, j;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			j = (k == 2'd3) ? 2'd0 : k;
			d = {k[1], k[0], j, j, k};
			nonmux <= k[0];
			dev(1, REG_CLK_SRC, d);
			dev(0, REG_CLK_SRC, 8'h0);
			chk("clk_rb", q, d);
			chk("dac_mult", dac_clk_mult, 4'd1 << k);
			chk("rx_mult", rx_clk_mult, MT[j]);
			chk("rx_div", rx_clk_div, ND[j]);
			chk("rx_half", rx_clk_half, k[0]);
			chk("adc_src", {adc_clk_from_rx, rx_sync_half}, {2{k[0]}});
			chk("tx_edge", tx_neg_edge, k[1]);
		end
		$display("t_clk done");
	endtask
	task automatic t_filt;
		int n;
		wait_tune();
		dev(1, REG_TUNE_TGT, 8'h20);
		dev(1, REG_FILT_SEL, 8'h1f);
		chk("tune_restart", tune_busy, 1'b1);
		chk("filt_on", {lpf_bypass, lpf_powerdown, one_pole_en, lpf_wideband, fast_bias,
			hpf_bypass}, 6'h3f);
		chk("cut_hi", cutoff_num, CUT_NUM_HIGH);
		chk("cut_den", cutoff_den, 9'd96);
		wait_tune();
		dev(1, REG_FILT_SEL, 8'hc0);
		dev(0, REG_FILT_SEL, 8'h0);
		chk("busy_ro", q, 8'h80);
		n = 0;
		repeat (PER + TUNE + 10) begin
			@(posedge mclk);
			n += (tune_busy !== 1'b0);
		end
		chk("no_periodic", n, 0);
		chk("filt_off", {lpf_bypass, lpf_powerdown, one_pole_en, lpf_wideband, fast_bias,
			hpf_bypass}, 6'h00);
		chk("cut_lo", cutoff_num, CUT_NUM_LOW);
		dev(1, REG_FILT_SEL, 8'h00);
		dev(0, REG_FILT_SEL, 8'h0);
		chk("busy_rb", q, 8'h40);
		wait_tune();
		n = 0;
		while (tune_busy !== 1'b1 && n < PER + 20) begin
			@(posedge mclk);
			n++;
		end
		chk("periodic", n >= PER - 5 && n <= PER + 5, 1);
		$display("t_filt done");
	endtask
	task automatic t_offset;
		int n;
		wait_tune();
		dev(1, REG_FILT_SEL, 8'ha0);
		dev(0, REG_FILT_SEL, 8'h0);
		chk("off_run", q, 8'ha0);
		chk("off_busy", offset_busy, 1'b1);
		n = 0;
		while (offset_busy === 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		dev(0, REG_FILT_SEL, 8'h0);
		chk("off_done", q, 8'h80);
		$display("t_offset done");
	endtask
	// gain set by the pins, judged at outputs and readback
	task automatic gstep(input int code, input logic w);
		int c, cg, fg;
		c = (code > 5'h15) ? 5'h15 : code; // oversize codes saturate
		cg = (c < 6) ? -6 : (c < 18) ? 6 * ((c - 6) / 3) : w ? 18 : 24;
		fg = (c < 6) ? 2 * c : (c < 18) ? 6 + 2 * ((c - 6) % 3) : w ? 12 : 2 * c - 30;
		av(1'b1, AV_GAIN, code, s);
		dev(0, REG_GAIN, 8'h0);
		chk("gain_rb", q, c);
		chk("gain_db", rx_gain_db, cg + fg);
		chk("coarse", coarse_gain_stage_db, cg);
		chk("fine", fine_gain_stage_db, fg);
	endtask
	task automatic t_gain;
		for (int i = 0; i < 24; i++) gstep(i, 1'b0);
		dev(1, REG_FILT_SEL, 8'h84);
		gstep(5'h11, 1'b1);
		gstep(5'h15, 1'b1);
		dev(1, REG_FILT_SEL, 8'h80);
		dev(1, REG_GAIN, 8'h29);
		av(1'b1, AV_GAIN, 32'h3, s);
		dev(0, REG_GAIN, 8'h0);
		chk("gain_reg", q, 8'h29);
		chk("gain_reg_db", rx_gain_db, 12);
		dev(1, REG_GAIN, 8'h1f);
		dev(0, REG_GAIN, 8'h0);
		chk("gain_src_off", q, 8'h09);
		$display("t_gain done");
	endtask
	task automatic t_tx;
		int n0;
		dev(1, REG_TX_SET, 8'h00);
		n0 = n_smp;
		txs(1'b0, 6'h0f, n0 + 1);
		txs(1'b1, 6'h2a, n0 + 1);
		txs(1'b0, 6'h15, n0 + 1);
		chk("ms_first", {20'(n_smp - n0), smp}, {20'd1, 12'ha95});
		dev(1, REG_TX_SET, 8'h04);
		txs(1'b1, 6'h15, n0 + 1);
		txs(1'b0, 6'h2a, n0 + 2);
		chk("ls_first", smp, 12'ha95);
		dev(1, REG_TX_SET, 8'h01);
		txs(1'b1, 6'h33, n0 + 3);
		chk("byp_a", smp, 12'hcc0);
		txs(1'b0, 6'h0c, n0 + 4);
		chk("byp_b", {20'(n_smp - n0), smp}, {20'd4, 12'h300});
		dev(1, REG_TX_SET, 8'h09);
		av(1'b1, AV_QUIET, 32'h0, s);
		av(1'b0, AV_QUIET, 32'h0, s);
		chk("quiet_pd", {s[0], interp_powerdown}, 2'b01);
		txs(1'b0, 6'h11, n0 + 5);
		chk("quiet_drop", n_smp - n0, 4);
		dev(1, REG_TX_SET, 8'h01);
		chk("quiet_off", interp_powerdown, 1'b0);
		av(1'b1, AV_QUIET, 32'h1, s);
		for (int i = 0; i < 8; i++) begin
			dev(1, REG_TX_SET, {IC[i], 4'h0});
			chk("interp_rate", interp_rate, IR[i]);
			chk("interp_kind", interp_kind, IK[i]);
		end
		$display("t_tx done");
	endtask
	// ------
	// verdict and main sequence
	// ------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_clk();
		t_filt();
		t_offset();
		t_gain();
		t_tx();
		results();
	end
endmodule
